// *** rtl/hhp_device.sv ***
`timescale 1ns/10ps
module hhp_device (
	// Clock and reset
	input  wire logic        mclk_in,
	input  wire logic        rstn_in,
	// Link to host
	hhp_if.device            port_if,
	// Network side process data
	input  wire logic [15:0] net_pd_in,
	input  wire logic        net_upd_in,
	output logic      [15:0] host_pd_out,
	output logic             host_pd_valid_out,
	// Requests to host objects and their answers
	input  wire logic        req_valid_in,
	input  wire logic [15:0] req_in,
	output logic             req_ready_out,
	output logic      [15:0] ans_out,
	output logic             ans_valid_out,
	// Indicator pins
	input  wire logic [3:0]  led_on_in,
	input  wire logic [1:0]  first_indicator_pair_in,
	output logic      [1:0]  first_indicator_pair_out,
	output logic      [1:0]  first_indicator_pair_oe_out,
	output logic      [1:0]  second_indicator_pair_out,
	output logic      [1:0]  second_indicator_pair_oe_out
);
	import hhp_pkg::*;

	// ==========================================================
	// State
	logic [7:0]  ctrl;
	logic [7:0]  stat;
	logic [7:0]  gpio_cfg;
	logic [15:0] pdw;
	logic [15:0] msw;
	logic [15:0] pdr;
	logic [15:0] msr;
	logic [7:0]  rdata;
	logic        net_pend;
	logic [15:0] net_buf;
	logic        req_pend;
	logic [15:0] req_buf;
	logic [15:0] hpd;
	logic        hpd_v;
	logic [15:0] ans;
	logic        ans_v;
	logic [1:0]  ind1;
	logic [1:0]  ind1_oe;
	logic [1:0]  ind2;
	logic [1:0]  ind2_oe;

	logic [7:0]  next_ctrl;
	logic [7:0]  next_stat;
	logic [7:0]  next_gpio_cfg;
	logic [15:0] next_pdw;
	logic [15:0] next_msw;
	logic [15:0] next_pdr;
	logic [15:0] next_msr;
	logic [7:0]  next_rdata;
	logic        next_net_pend;
	logic [15:0] next_net_buf;
	logic        next_req_pend;
	logic [15:0] next_req_buf;
	logic [15:0] next_hpd;
	logic        next_hpd_v;
	logic [15:0] next_ans;
	logic        next_ans_v;
	logic [1:0]  next_ind1;
	logic [1:0]  next_ind1_oe;
	logic [1:0]  next_ind2;
	logic [1:0]  next_ind2_oe;
	logic        ping;
	logic        led_mode;

	assign ping = port_if.wr && port_if.addr == A_CTRL;
	assign led_mode = gpio_cfg[GB_LED];

	// ==========================================================
	// Next state
	always_comb begin
		next_ctrl     = ctrl;
		next_stat     = stat;
		next_gpio_cfg = gpio_cfg;
		next_pdw      = pdw;
		next_msw      = msw;
		next_pdr      = pdr;
		next_msr      = msr;
		next_rdata    = 8'h00;
		next_net_pend = net_pend;
		next_net_buf  = net_buf;
		next_req_pend = req_pend;
		next_req_buf  = req_buf;
		next_hpd      = hpd;
		next_hpd_v    = 1'b0;
		next_ans      = ans;
		next_ans_v    = 1'b0;

		// Only the host-owned areas take writes; stores elsewhere fall through unanswered.
		if (port_if.wr) begin
			case (port_if.addr)
				A_GPIO: next_gpio_cfg = port_if.wdata;
				A_PDW0: next_pdw[7:0] = port_if.wdata;
				A_PDW1: next_pdw[15:8] = port_if.wdata;
				A_MSW0: next_msw[7:0] = port_if.wdata;
				A_MSW1: next_msw[15:8] = port_if.wdata;
				default: next_ctrl = ctrl;
			endcase
		end

		if (req_valid_in && !req_pend) begin
			next_req_pend = 1'b1;
			next_req_buf  = req_in;
		end

		// The exchange runs on the edge of the control write, so the pong is seen one cycle later.
		if (ping) begin
			next_ctrl = port_if.wdata;
			next_stat[SB_PONG] = port_if.wdata[CB_PING];
			next_hpd   = pdw;
			next_hpd_v = 1'b1;
			next_pdr   = net_buf;
			next_stat[SB_AUX] = net_pend;
			next_net_pend = 1'b0;
			if (port_if.wdata[CB_M]) begin
				next_ans   = msw;
				next_ans_v = 1'b1;
			end
			if (!port_if.wdata[CB_R]) begin
				next_stat[SB_M] = 1'b0;
			end else if (req_pend && !stat[SB_M]) begin
				next_stat[SB_M] = 1'b1;
				next_msr = req_buf;
				next_req_pend = req_valid_in;
				next_req_buf  = req_in;
			end
		end

		// A network update in the exchange cycle is kept for the next telegram.
		if (net_upd_in) begin
			next_net_pend = 1'b1;
			next_net_buf  = net_pd_in;
		end

		if (port_if.rd) begin
			case (port_if.addr)
				A_CTRL:    next_rdata = ctrl;
				A_STAT:    next_rdata = stat;
				A_TYPE_LO: next_rdata = MODULE_TYPE[7:0];
				A_TYPE_HI: next_rdata = MODULE_TYPE[15:8];
				A_GPIO:    next_rdata = gpio_cfg;
				A_PDW0:    next_rdata = pdw[7:0];
				A_PDW1:    next_rdata = pdw[15:8];
				A_PDR0:    next_rdata = pdr[7:0];
				A_PDR1:    next_rdata = pdr[15:8];
				A_MSW0:    next_rdata = msw[7:0];
				A_MSW1:    next_rdata = msw[15:8];
				A_MSR0:    next_rdata = msr[7:0];
				A_MSR1:    next_rdata = msr[15:8];
				default:   next_rdata = 8'h00;
			endcase
		end

		// Open-drain first pair sinks when lit; push-pull second pair is active low.
		next_ind1    = 2'b00;
		next_ind1_oe = led_mode ? led_on_in[1:0] : 2'b00;
		next_ind2    = led_mode ? ~led_on_in[3:2] : 2'b11;
		next_ind2_oe = {2{led_mode}};
	end

	// ==========================================================
	// Registers
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			ctrl     <= 8'h00;
			stat     <= 8'h00;
			gpio_cfg <= GPIO_RST;
			pdw      <= 16'h0000;
			msw      <= 16'h0000;
			pdr      <= 16'h0000;
			msr      <= 16'h0000;
			rdata    <= 8'h00;
			net_pend <= 1'b0;
			net_buf  <= 16'h0000;
			req_pend <= 1'b0;
			req_buf  <= 16'h0000;
			hpd      <= 16'h0000;
			hpd_v    <= 1'b0;
			ans      <= 16'h0000;
			ans_v    <= 1'b0;
			ind1     <= 2'b00;
			ind1_oe  <= 2'b00;
			ind2     <= 2'b11;
			ind2_oe  <= 2'b00;
		end else begin
			ctrl     <= next_ctrl;
			stat     <= next_stat;
			gpio_cfg <= next_gpio_cfg;
			pdw      <= next_pdw;
			msw      <= next_msw;
			pdr      <= next_pdr;
			msr      <= next_msr;
			rdata    <= next_rdata;
			net_pend <= next_net_pend;
			net_buf  <= next_net_buf;
			req_pend <= next_req_pend;
			req_buf  <= next_req_buf;
			hpd      <= next_hpd;
			hpd_v    <= next_hpd_v;
			ans      <= next_ans;
			ans_v    <= next_ans_v;
			ind1     <= next_ind1;
			ind1_oe  <= next_ind1_oe;
			ind2     <= next_ind2;
			ind2_oe  <= next_ind2_oe;
		end
	end

	// ==========================================================
	// Outputs
	assign port_if.rdata = rdata;
	assign host_pd_out = hpd;
	assign host_pd_valid_out = hpd_v;
	assign req_ready_out = !req_pend;
	assign ans_out = ans;
	assign ans_valid_out = ans_v;
	assign first_indicator_pair_out = ind1;
	assign first_indicator_pair_oe_out = ind1_oe;
	assign second_indicator_pair_out = ind2;
	assign second_indicator_pair_oe_out = ind2_oe;

endmodule : hhp_device

// *** rtl/hhp_host.sv ***
`timescale 1ns/10ps
module hhp_host (
	// Clock and reset
	input  wire logic       mclk_in,
	input  wire logic       rstn_in,
	// Link to device
	hhp_if.host             port_if,
	// Software register port
	input  wire logic [3:0] sw_addr_in,
	input  wire logic [7:0] sw_wdata_in,
	input  wire logic       sw_wr_in,
	input  wire logic       sw_rd_in,
	output logic      [7:0] sw_rdata_out,
	output logic            irq_out
);
	import hhp_pkg::*;

	typedef enum logic [7:0] {
		S_IDLE  = 8'b00000001,
		S_IDENT = 8'b00000010,
		S_WRITE = 8'b00000100,
		S_CTRL  = 8'b00001000,
		S_POLL  = 8'b00010000,
		S_READ  = 8'b00100000,
		S_DRAIN = 8'b01000000,
		S_DONE  = 8'b10000000
	} hhp_state_e;

	hhp_state_e state, next_state;
	logic [7:0]  rx [0:6];
	logic [7:0]  next_rx [0:6];
	logic [2:0]  idx, next_idx;
	logic        rd_pend, next_rd_pend;
	logic [2:0]  rd_tag, next_rd_tag;
	logic [2:0]  cur_tag, next_cur_tag;
	logic [7:0]  addr, next_addr;
	logic [7:0]  wdata, next_wdata;
	logic        wr, next_wr;
	logic        rd, next_rd;
	logic [4:0]  hctrl, next_hctrl;
	logic        is_id, next_is_id;
	logic        type_ok, next_type_ok;
	logic        tgl, next_tgl;
	logic        r_bit, next_r_bit;
	logic        sent_ans, next_sent_ans;
	logic        req_pend, next_req_pend;
	logic        ans_rdy, next_ans_rdy;
	logic [7:0]  ans_data, next_ans_data;
	logic [15:0] pd_tx, next_pd_tx;
	logic [2:0]  evt, next_evt;
	logic [2:0]  mask, next_mask;
	logic [9:0]  tmo, next_tmo;
	logic [7:0]  srd, next_srd;

	// Read tags: 0/1 type, 2 status, 3/4 process data, 5/6 message.
	function automatic logic [7:0] tag_addr(input logic [2:0] t);
		case (t)
			3'd0:    tag_addr = A_TYPE_LO;
			3'd1:    tag_addr = A_TYPE_HI;
			3'd2:    tag_addr = A_STAT;
			3'd3:    tag_addr = A_PDR0;
			3'd4:    tag_addr = A_PDR1;
			3'd5:    tag_addr = A_MSR0;
			default: tag_addr = A_MSR1;
		endcase
	endfunction : tag_addr

	// ==========================================================
	// Next state
	always_comb begin
		next_state = state;
		next_rx = rx;
		next_idx = idx;
		// Read data stand in the cycle after the strobe, so the capture trails each read by one cycle.
		next_rd_pend = rd;
		next_rd_tag = cur_tag;
		next_cur_tag = cur_tag;
		next_addr = addr;
		next_wdata = wdata;
		next_wr = 1'b0;
		next_rd = 1'b0;
		next_hctrl = hctrl;
		next_is_id = is_id;
		next_type_ok = type_ok;
		next_tgl = tgl;
		next_r_bit = r_bit;
		next_sent_ans = sent_ans;
		next_req_pend = req_pend;
		next_ans_rdy = ans_rdy;
		next_ans_data = ans_data;
		next_pd_tx = pd_tx;
		next_evt = evt;
		next_mask = mask;
		next_tmo = 10'd0;
		next_srd = 8'h00;

		if (rd_pend) begin
			next_rx[rd_tag] = port_if.rdata;
		end

		case (state)
			S_IDLE: begin
				if (sw_wr_in && sw_addr_in == H_CTRL && sw_wdata_in[HC_ID]) begin
					next_state = S_IDENT;
					next_is_id = 1'b1;
					next_idx = 3'd0;
				end else if (sw_wr_in && sw_addr_in == H_CTRL && sw_wdata_in[HC_GO]) begin
					next_state = S_WRITE;
					next_is_id = 1'b0;
					next_idx = 3'd0;
				end
			end
			S_IDENT: begin
				next_rd = 1'b1;
				next_cur_tag = idx;
				next_addr = tag_addr(idx);
				next_idx = idx + 3'd1;
				if (idx == 3'd1) begin
					next_state = S_DRAIN;
				end
			end
			S_WRITE: begin
				next_wr = 1'b1;
				case (idx)
					3'd0: begin
						next_addr = A_PDW0;
						next_wdata = pd_tx[7:0];
					end
					3'd1: begin
						next_addr = A_PDW1;
						next_wdata = pd_tx[15:8];
					end
					3'd2: begin
						next_addr = A_MSW0;
						next_wdata = rx[5];
					end
					default: begin
						next_addr = A_MSW1;
						next_wdata = ans_data;
						next_state = S_CTRL;
					end
				endcase
				next_idx = idx + 3'd1;
			end
			S_CTRL: begin
				next_wr = 1'b1;
				next_addr = A_CTRL;
				next_wdata = {~tgl, r_bit, ans_rdy, 5'h00};
				next_tgl = ~tgl;
				next_sent_ans = ans_rdy;
				next_state = S_POLL;
			end
			S_POLL: begin
				if (rd_pend && port_if.rdata[SB_PONG] == tgl) begin
					next_state = S_READ;
					next_idx = 3'd3;
				end else if (!rd_pend && !rd) begin
					next_rd = 1'b1;
					next_cur_tag = 3'd2;
					next_addr = A_STAT;
				end
			end
			S_READ: begin
				next_rd = 1'b1;
				next_cur_tag = idx;
				next_addr = tag_addr(idx);
				next_idx = idx + 3'd1;
				if (idx == 3'd6) begin
					next_state = S_DRAIN;
				end
			end
			S_DRAIN: next_state = S_DONE;
			S_DONE: begin
				next_state = S_IDLE;
				if (is_id) begin
					// The high byte answers in this very cycle, so it is taken before it is registered.
					next_type_ok = {next_rx[1], rx[0]} == MODULE_TYPE;
				end else begin
					next_evt[EV_TEL] = 1'b1;
					if (sent_ans) begin
						next_req_pend = 1'b0;
						next_ans_rdy = 1'b0;
					end
					// Capturing a message drops ready, which is legal while the message flag stands.
					if (rx[2][SB_M] && r_bit) begin
						next_req_pend = 1'b1;
						next_r_bit = 1'b0;
						next_evt[EV_REQ] = 1'b1;
					end else if (!rx[2][SB_M] && !(req_pend && !sent_ans)) begin
						next_r_bit = 1'b1;
					end
				end
			end
			default: next_state = S_IDLE;
		endcase

		// Every request is answered; silence from software turns into an error answer.
		if (req_pend && !ans_rdy) begin
			next_tmo = tmo + 10'd1;
			if (tmo == 10'(ANS_TMO_CYC - 1)) begin
				next_ans_rdy = 1'b1;
				next_ans_data = ANS_ERR;
				next_evt[EV_TMO] = 1'b1;
			end
		end

		if (sw_wr_in) begin
			case (sw_addr_in)
				H_CTRL: begin
					next_hctrl = sw_wdata_in[4:0];
					if (sw_wdata_in[HC_DROP] && state == S_IDLE) begin
						if (rx[2][SB_M]) begin
							next_r_bit = 1'b0;
						end else if (sw_wdata_in[HC_SER] && sw_wdata_in[HC_FRAG]) begin
							next_r_bit = 1'b0;
						end
					end
				end
				H_EVT:  next_evt = next_evt & ~sw_wdata_in[2:0];
				H_MASK: next_mask = sw_wdata_in[2:0];
				H_PDT0: next_pd_tx[7:0] = sw_wdata_in;
				H_PDT1: next_pd_tx[15:8] = sw_wdata_in;
				H_ANS: begin
					if (req_pend && !ans_rdy) begin
						next_ans_rdy = 1'b1;
						next_ans_data = sw_wdata_in;
					end
				end
				default: next_mask = next_mask;
			endcase
		end

		// Events raised in this cycle survive a clear written in the same cycle.
		if (state == S_DONE && !is_id) begin
			next_evt[EV_TEL] = 1'b1;
			next_evt[EV_REQ] = next_evt[EV_REQ] | (rx[2][SB_M] & r_bit);
		end
		if (req_pend && !ans_rdy && tmo == 10'(ANS_TMO_CYC - 1)) begin
			next_evt[EV_TMO] = 1'b1;
		end

		if (sw_rd_in) begin
			case (sw_addr_in)
				H_CTRL:  next_srd = {3'b000, hctrl};
				H_STAT:  next_srd = {3'b000, ans_rdy, r_bit, req_pend, type_ok, state != S_IDLE};
				H_EVT:   next_srd = {5'h00, evt};
				H_MASK:  next_srd = {5'h00, mask};
				H_PDT0:  next_srd = pd_tx[7:0];
				H_PDT1:  next_srd = pd_tx[15:8];
				H_PDR0:  next_srd = rx[3];
				H_PDR1:  next_srd = rx[4];
				H_REQ0:  next_srd = rx[5];
				H_REQ1:  next_srd = rx[6];
				H_ANS:   next_srd = ans_data;
				default: next_srd = 8'h00;
			endcase
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			state <= S_IDLE;
			for (int i = 0; i < 7; i++) begin
				rx[i] <= 8'h00;
			end
			idx <= 3'd0;
			rd_pend <= 1'b0;
			rd_tag <= 3'd0;
			cur_tag <= 3'd0;
			addr <= 8'h00;
			wdata <= 8'h00;
			wr <= 1'b0;
			rd <= 1'b0;
			hctrl <= 5'h00;
			is_id <= 1'b0;
			type_ok <= 1'b0;
			tgl <= 1'b0;
			r_bit <= 1'b0;
			sent_ans <= 1'b0;
			req_pend <= 1'b0;
			ans_rdy <= 1'b0;
			ans_data <= 8'h00;
			pd_tx <= 16'h0000;
			evt <= 3'b000;
			mask <= 3'b000;
			tmo <= 10'd0;
			srd <= 8'h00;
		end else begin
			state <= next_state;
			rx <= next_rx;
			idx <= next_idx;
			rd_pend <= next_rd_pend;
			rd_tag <= next_rd_tag;
			cur_tag <= next_cur_tag;
			addr <= next_addr;
			wdata <= next_wdata;
			wr <= next_wr;
			rd <= next_rd;
			hctrl <= next_hctrl;
			is_id <= next_is_id;
			type_ok <= next_type_ok;
			tgl <= next_tgl;
			r_bit <= next_r_bit;
			sent_ans <= next_sent_ans;
			req_pend <= next_req_pend;
			ans_rdy <= next_ans_rdy;
			ans_data <= next_ans_data;
			pd_tx <= next_pd_tx;
			evt <= next_evt;
			mask <= next_mask;
			tmo <= next_tmo;
			srd <= next_srd;
		end
	end

	assign port_if.addr = addr;
	assign port_if.wdata = wdata;
	assign port_if.wr = wr;
	assign port_if.rd = rd;
	assign sw_rdata_out = srd;
	assign irq_out = |(evt & mask);

endmodule : hhp_host

// *** rtl/hhp_if.sv ***
`timescale 1ns/10ps
interface hhp_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	modport device (
		input  addr,
		input  wdata,
		input  wr,
		input  rd,
		output rdata
	);
	modport host (
		output addr,
		output wdata,
		output wr,
		output rd,
		input  rdata
	);
endinterface : hhp_if

// *** rtl/hhp_pkg.sv ***
package hhp_pkg;
	// ==========================================================
	// Link map
	localparam logic [7:0] A_CTRL    = 8'h00;
	localparam logic [7:0] A_STAT    = 8'h01;
	localparam logic [7:0] A_TYPE_LO = 8'h02;
	localparam logic [7:0] A_TYPE_HI = 8'h03;
	localparam logic [7:0] A_GPIO    = 8'h04;
	localparam logic [7:0] A_PDW0    = 8'h10;
	localparam logic [7:0] A_PDW1    = 8'h11;
	localparam logic [7:0] A_PDR0    = 8'h18;
	localparam logic [7:0] A_PDR1    = 8'h19;
	localparam logic [7:0] A_MSW0    = 8'h20;
	localparam logic [7:0] A_MSW1    = 8'h21;
	localparam logic [7:0] A_MSR0    = 8'h28;
	localparam logic [7:0] A_MSR1    = 8'h29;
	localparam int CB_PING = 7;
	localparam int CB_R    = 6;
	localparam int CB_M    = 5;
	localparam int CB_AUX  = 4;
	localparam int SB_PONG = 7;
	localparam int SB_M    = 6;
	localparam int SB_AUX  = 4;
	localparam int GB_LED  = 0;
	localparam logic [7:0] GPIO_RST = 8'h01;
	// Arbitrary neutral identity value.
	localparam logic [15:0] MODULE_TYPE = 16'h5c3a;
	// ==========================================================
	// Timing
	localparam int CLK_NS       = 40;
	localparam int PING_RESP_NS = 2000;
	localparam int PING_RESP_CYC = PING_RESP_NS / CLK_NS;
	localparam int ANS_TMO_NS   = 20000;
	localparam int ANS_TMO_CYC  = ANS_TMO_NS / CLK_NS;
	// ==========================================================
	// Host controller registers
	localparam logic [3:0] H_CTRL  = 4'h0;
	localparam logic [3:0] H_STAT  = 4'h1;
	localparam logic [3:0] H_EVT   = 4'h2;
	localparam logic [3:0] H_MASK  = 4'h3;
	localparam logic [3:0] H_PDT0  = 4'h4;
	localparam logic [3:0] H_PDT1  = 4'h5;
	localparam logic [3:0] H_PDR0  = 4'h6;
	localparam logic [3:0] H_PDR1  = 4'h7;
	localparam logic [3:0] H_REQ0  = 4'h8;
	localparam logic [3:0] H_REQ1  = 4'h9;
	localparam logic [3:0] H_ANS   = 4'ha;
	localparam int HC_GO   = 0;
	localparam int HC_ID   = 1;
	localparam int HC_SER  = 2;
	localparam int HC_FRAG = 3;
	localparam int HC_DROP = 4;
	localparam int EV_TEL  = 0;
	localparam int EV_REQ  = 1;
	localparam int EV_TMO  = 2;
	localparam logic [7:0] ANS_ERR = 8'hff;
endpackage : hhp_pkg

// *** verification/hhp_chk.sv ***
`timescale 1ns/10ps
module hhp_chk (
	// Clock and reset
	input wire logic       mclk_in,
	input wire logic       rstn_in,
	// Link signals
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata
);
	import hhp_pkg::*;
	// ==========================================================
	// Helper state
	// The host may only drop its ready bit after it has seen the message flag, so the last flag read is kept.
	// hhp_host also drops it without the flag when HC_DROP is written with HC_SER and HC_FRAG set.
	logic ping_t;
	logic last_r;
	logic seen_m;
	logic stat_d;
	logic msw_d;
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			ping_t <= 1'b0;
			last_r <= 1'b0;
			seen_m <= 1'b0;
			stat_d <= 1'b0;
			msw_d  <= 1'b0;
		end else begin
			stat_d <= rd && addr == A_STAT;
			msw_d  <= wr && addr == A_MSW1;
			if (wr && addr == A_CTRL) begin
				ping_t <= wdata[CB_PING];
				last_r <= wdata[CB_R];
			end
			if (stat_d) begin
				seen_m <= rdata[SB_M];
			end
		end
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);
	sequence s_ping; wr && addr == A_CTRL; endsequence
	sequence s_stat_rd; rd && addr == A_STAT; endsequence
	property p_pong; s_stat_rd |=> rdata[SB_PONG] == ping_t; endproperty
	property p_poll; s_ping |-> ##[1:60] s_stat_rd; endproperty
	property p_type_lo; rd && addr == A_TYPE_LO |=> rdata == MODULE_TYPE[7:0]; endproperty
	property p_type_hi; rd && addr == A_TYPE_HI |=> rdata == MODULE_TYPE[15:8]; endproperty
	property p_idle; !rd |=> rdata == 8'h00; endproperty
	property p_one_strobe; !(wr && rd); endproperty
	property p_r_clear; s_ping ##0 (last_r && !wdata[CB_R]) |-> seen_m; endproperty
	property p_tel_order; s_ping |-> msw_d; endproperty
	a_pong: assert property (p_pong) else $error("pong bit differs from last ping");
	a_poll: assert property (p_poll) else $error("no status poll after ping");
	a_type_lo: assert property (p_type_lo) else $error("type low byte wrong");
	a_type_hi: assert property (p_type_hi) else $error("type high byte wrong");
	a_idle: assert property (p_idle) else $error("read data not zero outside read answer");
	a_one_strobe: assert property (p_one_strobe) else $error("write and read strobes together");
	a_r_clear: assert property (p_r_clear) else $error("ready bit dropped without message flag");
	a_tel_order: assert property (p_tel_order) else $error("ping not preceded by message write");
endmodule : hhp_chk

// *** verification/hhp_tb_top.sv ***
`timescale 1ns/10ps
module hhp_tb_top;
	import hhp_pkg::*;
	// ==========================================================
	// Signals
	logic        clk;
	logic        rstn;
	logic [15:0] npd;
	logic        nupd;
	logic [15:0] rq;
	logic        rqv;
	logic        rqr;
	logic [3:0]  led;
	logic [3:0]  sa;
	logic [7:0]  swd;
	logic        swr;
	logic        srd;
	logic [7:0]  srdata;
	logic        irq;
	logic [15:0] hpd;
	logic [15:0] hpd2;
	logic [15:0] ans;
	logic        av;
	logic [1:0]  f_o;
	logic [1:0]  f_oe;
	logic [1:0]  s_o;
	logic [1:0]  s_oe;
	logic [1:0]  f2_oe;
	logic [1:0]  s2_o;
	logic [1:0]  s2_oe;
	logic        hpv;
	logic        hvs;
	logic [15:0] acap;
	logic [7:0]  st1;
	logic        sd;
	logic [7:0]  d;
	logic [7:0]  d0;
	int          checks;
	int          miscompares;
	localparam logic [7:0] PROT [5] = '{A_STAT, A_PDR0, A_PDR1, A_MSR0, A_TYPE_LO};
	hhp_if bus1 ();
	hhp_if bus2 ();
	// ==========================================================
	// Design under test
	hhp_device u_hhp_device (.mclk_in(clk), .rstn_in(rstn), .port_if(bus1), .net_pd_in(npd), .net_upd_in(nupd),
		.host_pd_out(hpd), .host_pd_valid_out(hpv), .req_valid_in(rqv), .req_in(rq), .req_ready_out(rqr),
		.ans_out(ans), .ans_valid_out(av), .led_on_in(led), .first_indicator_pair_in(2'b00),
		.first_indicator_pair_out(f_o), .first_indicator_pair_oe_out(f_oe),
		.second_indicator_pair_out(s_o), .second_indicator_pair_oe_out(s_oe));
	hhp_host u_hhp_host (.mclk_in(clk), .rstn_in(rstn), .port_if(bus1), .sw_addr_in(sa), .sw_wdata_in(swd),
		.sw_wr_in(swr), .sw_rd_in(srd), .sw_rdata_out(srdata), .irq_out(irq));
	// The second device is driven straight by the bench so that misbehaving host writes can be tried.
	hhp_device u_hhp_device_2 (.mclk_in(clk), .rstn_in(rstn), .port_if(bus2), .net_pd_in(npd), .net_upd_in(nupd),
		.host_pd_out(hpd2), .host_pd_valid_out(), .req_valid_in(1'b0), .req_in(16'h0000), .req_ready_out(),
		.ans_out(), .ans_valid_out(), .led_on_in(led), .first_indicator_pair_in(2'b00),
		.first_indicator_pair_out(), .first_indicator_pair_oe_out(f2_oe),
		.second_indicator_pair_out(s2_o), .second_indicator_pair_oe_out(s2_oe));
	hhp_chk u_hhp_chk (.mclk_in(clk), .rstn_in(rstn), .addr(bus1.addr), .wdata(bus1.wdata), .wr(bus1.wr),
		.rd(bus1.rd), .rdata(bus1.rdata));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		sd <= bus1.rd && bus1.addr == A_STAT;
		if (sd) st1 <= bus1.rdata;
		if (av === 1'b1) acap <= ans;
		if (hpv === 1'b1) hvs <= 1'b1;
	end
	// ==========================================================
	// Tasks
	task automatic summarize;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic sw_wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		sa <= a;
		swd <= v;
		swr <= 1'b1;
		@(posedge clk);
		swr <= 1'b0;
	endtask : sw_wr
	task automatic sw_rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		sa <= a;
		srd <= 1'b1;
		@(posedge clk);
		srd <= 1'b0;
		#1 v = srdata;
	endtask : sw_rd
	task automatic ln_wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		bus2.addr <= a;
		bus2.wdata <= v;
		bus2.wr <= 1'b1;
		@(posedge clk);
		bus2.wr <= 1'b0;
	endtask : ln_wr
	task automatic ln_rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		bus2.addr <= a;
		bus2.rd <= 1'b1;
		@(posedge clk);
		bus2.rd <= 1'b0;
		#1 v = bus2.rdata;
	endtask : ln_rd
	task automatic wait_bit(input logic [3:0] a, input int b, input logic v);
		for (int i = 0; i < 1500; i++) begin
			sw_rd(a, d);
			if (d[b] === v) return;
		end
		miscompares++;
		$display("[ERR] wait on register %h bit %0d expected %b seen %b", a, b, v, d[b]);
		summarize();
	endtask : wait_bit
	task automatic tel;
		sw_wr(H_CTRL, 8'h01);
		wait_bit(H_STAT, 0, 1'b0);
	endtask : tel
	task automatic upd;
		@(posedge clk);
		nupd <= 1'b1;
		@(posedge clk);
		nupd <= 1'b0;
	endtask : upd
	task automatic post_req(input logic [15:0] r);
		sw_wr(H_EVT, 8'h07);
		@(posedge clk);
		rqv <= 1'b1;
		rq <= r;
		for (int i = 0; i < 50; i++) begin
			@(posedge clk);
			if (rqr === 1'b1) break;
		end
		rqv <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			tel();
			sw_rd(H_EVT, d);
			if (d[EV_REQ] === 1'b1) break;
		end
		chk("evt_req", d[EV_REQ], 1'b1);
		sw_rd(H_REQ0, d);
		chk("req_obj", d, r[7:0]);
		sw_rd(H_REQ1, d);
		chk("req_cmd", d, r[15:8]);
	endtask : post_req
	// ==========================================================
	// Main sequence
	initial begin
		checks = 0;
		miscompares = 0;
		{rstn, nupd, rqv, swr, srd, hvs} = '0;
		{rq, sa, swd} = '0;
		{bus2.addr, bus2.wdata, bus2.wr, bus2.rd} = '0;
		npd = 16'hbeef;
		led = 4'b0110;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			repeat (3) @(posedge clk);
			#1;
			chk("ind1_oe", f_oe, led[1:0]);
			chk("ind1_out", f_o, 2'b00);
			chk("ind2_oe", s_oe, 2'b11);
			chk("ind2_out", s_o, {14'h0000, ~led[3:2]});
			led <= 4'b1001;
		end
		sw_wr(H_CTRL, 8'h02);
		wait_bit(H_STAT, 0, 1'b0);
		sw_rd(H_STAT, d);
		chk("type_ok", d[1], 1'b1);
		sw_wr(H_MASK, 8'h01);
		sw_wr(H_PDT0, 8'ha5);
		sw_wr(H_PDT1, 8'h3c);
		upd();
		tel();
		chk("pd_in", hpd, 16'h3ca5);
		chk("pd_valid", hvs, 1'b1);
		chk("aux_upd", st1[SB_AUX], 1'b1);
		sw_rd(H_PDR0, d);
		chk("pdr0", d, 8'hef);
		sw_rd(H_PDR1, d);
		chk("pdr1", d, 8'hbe);
		chk("irq_set", irq, 1'b1);
		sw_wr(H_EVT, 8'h07);
		repeat (2) @(posedge clk);
		#1;
		chk("irq_clr", irq, 1'b0);
		sw_wr(H_MASK, 8'h00);
		tel();
		chk("aux_idle", st1[SB_AUX], 1'b0);
		chk("irq_mask", irq, 1'b0);
		sw_rd(H_EVT, d);
		chk("evt_tel", d[EV_TEL], 1'b1);
		// The same data again still counts as an update.
		upd();
		tel();
		chk("aux_same", st1[SB_AUX], 1'b1);
		post_req(16'h0712);
		sw_wr(H_ANS, 8'h5a);
		tel();
		chk("ans", acap, 16'h5a12);
		post_req(16'h09ee);
		wait_bit(H_EVT, EV_TMO, 1'b1);
		tel();
		chk("ans_tmo", acap, {ANS_ERR, 8'hee});
		ln_wr(A_PDW0, 8'h11);
		ln_wr(A_PDW1, 8'h22);
		upd();
		ln_wr(A_CTRL, 8'h90);
		ln_rd(A_STAT, d);
		chk("pong_hi", d[SB_PONG], 1'b1);
		chk("aux2", d[SB_AUX], 1'b1);
		chk("pd2", hpd2, 16'h2211);
		ln_wr(A_CTRL, 8'h00);
		ln_rd(A_STAT, d);
		chk("pong_lo", d[SB_PONG], 1'b0);
		chk("aux2_idle", d[SB_AUX], 1'b0);
		foreach (PROT[i]) begin
			ln_rd(PROT[i], d0);
			ln_wr(PROT[i], ~d0);
			ln_rd(PROT[i], d);
			chk("protected", d, d0);
		end
		ln_rd(8'h05, d);
		chk("unmapped", d, 8'h00);
		ln_rd(A_GPIO, d);
		chk("gpio_rst", d, GPIO_RST);
		ln_wr(A_GPIO, 8'h00);
		repeat (2) @(posedge clk);
		#1;
		chk("oe1_off", f2_oe, 2'b00);
		chk("oe2_off", s2_oe, 2'b00);
		chk("out2_off", s2_o, 2'b11);
		sw_wr(H_CTRL, 8'h10);
		sw_rd(H_STAT, d);
		chk("r_keep", d[3], 1'b1);
		sw_wr(H_CTRL, 8'h1c);
		sw_rd(H_STAT, d);
		chk("r_drop", d[3], 1'b0);
		summarize();
	end
endmodule : hhp_tb_top
